// *** shared/fspc_pkg.sv ***
// Constants and types for the flash self-programming controller
package fspc_pkg;

    // Register byte offsets on the slave bus
    localparam logic [4:0] OFF_PAGE = 5'h00;
    localparam logic [4:0] OFF_EADDR = 5'h04;
    localparam logic [4:0] OFF_DLOW = 5'h08;
    localparam logic [4:0] OFF_DHIGH = 5'h0C;
    localparam logic [4:0] OFF_CTRL = 5'h10;
    localparam logic [4:0] OFF_KEY = 5'h14;

    // Control register fields
    localparam int CTRL_START_BIT = 15;
    localparam int CTRL_PROGRAM_ENABLE_BIT_BIT = 14;
    localparam int CTRL_ERR_BIT = 13;
    localparam int CTRL_ERASE_BIT = 6;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] CTRL_RD_MASK = 16'hE04F;

    // Operation codes
    localparam logic [3:0] OP_BULK_ERASE = 4'hF;
    localparam logic [3:0] OP_WORD_PROG = 4'h3;
    localparam logic [3:0] OP_PAGE_ERASE = 4'h2;
    localparam logic [3:0] OP_ROW_PROG = 4'h1;

    // Unlock keys
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;

    // Array geometry: row size in words, masks in program address units (two per word)
    localparam int ROW_WORDS = 64;
    localparam logic [23:0] ROW_ALIGN_MASK = 24'hFFFF80;
    localparam logic [23:0] BLOCK_ALIGN_MASK = 24'hFFFC00;
    localparam int CFG_PAGE_BIT = 7;

    // Self-timed operation durations
    localparam int CLK_PERIOD_NS = 50;
    localparam int PROG_TIME_NS = 20000;
    localparam int ERASE_TIME_NS = 100000;
    localparam int PROG_CYC = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ERASE_CYC = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        FSPC_IDLE = 2'b00,
        FSPC_STREAM = 2'b01,
        FSPC_WAIT = 2'b10,
        FSPC_DONE = 2'b11
    } fspc_state_e;

    // Command toward the flash array macro
    typedef struct packed {
        logic [23:0] addr;
        logic [23:0] wdata;
        logic prog;
        logic erase;
        logic bulk;
    } fspc_cmd_s;

endpackage

// *** rtl/fspc_ctrl.sv ***
// Flash self-programming controller with holding latches and unlock sequencing
module fspc_ctrl
    import fspc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [4:0] avs_address,
    input wire logic [3:0] avs_byteenable,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output fspc_pkg::fspc_cmd_s fl_cmd,
    input wire logic [23:0] fl_rdata,
    output logic cpu_stall
);
    import fspc_pkg::*;

    fspc_state_e state_q;
    logic [7:0] page_q;
    logic [15:0] ea_q;
    logic start_q, program_enable_bit_q, err_q, erase_q;
    logic [3:0] op_q;
    logic [1:0] key_q;
    logic ack_q;
    logic [31:0] rdata_q;
    fspc_cmd_s cmd_q;
    logic [23:0] latch_mem [ROW_WORDS];
    logic [23:0] op_addr_q;
    logic [5:0] idx_q;
    logic [11:0] tmr_q;
    logic op_row_q, op_word_q, op_bulk_q;

    logic busy, req, wr_fire, rd_fire;
    logic sel_page, sel_ea, sel_dlow, sel_dhigh, sel_ctrl, sel_key;
    logic [23:0] tbl_addr;
    logic [5:0] tbl_idx;
    logic [15:0] be_mask, ctrl_wd, ctrl_rd;
    logic start_req, start_ok, op_valid;

    assign busy = state_q != FSPC_IDLE;
    assign req = avs_read | avs_write;
    assign wr_fire = ce & avs_write & ack_q;
    assign rd_fire = ce & avs_read & ack_q;
    assign tbl_addr = {page_q, ea_q};
    assign tbl_idx = ea_q[6:1];
    assign be_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    // Every access takes two enabled cycles; nothing is answered while busy
    assign avs_waitrequest = req & (~ack_q | ~ce);
    assign avs_readdata = rdata_q;
    assign fl_cmd = cmd_q;
    assign cpu_stall = busy;

    always_comb begin
        sel_page = 1'b0;
        sel_ea = 1'b0;
        sel_dlow = 1'b0;
        sel_dhigh = 1'b0;
        sel_ctrl = 1'b0;
        sel_key = 1'b0;
        if (avs_address == OFF_PAGE) begin
            sel_page = 1'b1;
        end else if (avs_address == OFF_EADDR) begin
            sel_ea = 1'b1;
        end else if (avs_address == OFF_DLOW) begin
            sel_dlow = 1'b1;
        end else if (avs_address == OFF_DHIGH) begin
            sel_dhigh = 1'b1;
        end else if (avs_address == OFF_CTRL) begin
            sel_ctrl = 1'b1;
        end else if (avs_address == OFF_KEY) begin
            sel_key = 1'b1;
        end
    end

    // Control word as read, and as it would be after this write
    assign ctrl_rd = {start_q, program_enable_bit_q, err_q, 6'h00, erase_q, 2'b00, op_q} & CTRL_RD_MASK;
    assign ctrl_wd = (ctrl_rd & ~be_mask) | (avs_writedata[15:0] & be_mask);
    assign start_req = wr_fire & sel_ctrl & avs_byteenable[1] & avs_writedata[CTRL_START_BIT] & ~start_q;
    assign start_ok = start_req & ctrl_wd[CTRL_PROGRAM_ENABLE_BIT_BIT] & (key_q == 2'd2);

    always_comb begin
        op_valid = 1'b0;
        if (ctrl_wd[CTRL_ERASE_BIT]) begin
            op_valid = (ctrl_wd[3:0] == OP_BULK_ERASE) | (ctrl_wd[3:0] == OP_PAGE_ERASE);
        end else begin
            op_valid = (ctrl_wd[3:0] == OP_WORD_PROG) | (ctrl_wd[3:0] == OP_ROW_PROG);
        end
    end

    // Bus acknowledge phase
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ack_q <= 1'b0;
        end else if (ce) begin
            ack_q <= req & ~ack_q & ~busy;
        end
    end

    // Read data captured in the first cycle
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= 32'h00000000;
        end else if (ce && avs_read && !ack_q) begin
            if (sel_page) begin
                rdata_q <= {24'h000000, page_q};
            end else if (sel_ea) begin
                rdata_q <= {16'h0000, ea_q};
            end else if (sel_dlow) begin
                rdata_q <= {16'h0000, fl_rdata[15:0]};
            end else if (sel_dhigh) begin
                rdata_q <= {24'h000000, fl_rdata[23:16]};
            end else if (sel_ctrl) begin
                rdata_q <= {16'h0000, ctrl_rd};
            end else begin
                rdata_q <= 32'h00000000;
            end
        end
    end

    // Page and effective address registers
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            page_q <= 8'h00;
            ea_q <= 16'h0000;
        end else if (wr_fire) begin
            if (sel_page && avs_byteenable[0]) begin
                page_q <= avs_writedata[7:0];
            end
            if (sel_ea) begin
                ea_q <= (ea_q & ~be_mask) | (avs_writedata[15:0] & be_mask);
            end
        end
    end

    // Holding latches; no reset, contents start unknown
    always_ff @(posedge clk_sys) begin
        if (wr_fire && !page_q[CFG_PAGE_BIT]) begin
            if (sel_dlow) begin
                if (avs_byteenable[0]) begin
                    latch_mem[tbl_idx][7:0] <= avs_writedata[7:0];
                end
                if (avs_byteenable[1]) begin
                    latch_mem[tbl_idx][15:8] <= avs_writedata[15:8];
                end
            end else if (sel_dhigh && avs_byteenable[0]) begin
                latch_mem[tbl_idx][23:16] <= avs_writedata[7:0];
            end
        end
    end

    // Unlock key sequencer: 0 locked, 1 first key seen, 2 unlocked
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            key_q <= 2'd0;
        end else if (wr_fire) begin
            if (sel_key && avs_byteenable[0] && avs_writedata[7:0] == KEY_FIRST) begin
                key_q <= 2'd1;
            end else if (sel_key && avs_byteenable[0] && avs_writedata[7:0] == KEY_SECOND && key_q == 2'd1) begin
                key_q <= 2'd2;
            end else begin
                key_q <= 2'd0;
            end
        end
    end

    // Control register
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            start_q <= CTRL_RESET[CTRL_START_BIT];
            program_enable_bit_q <= CTRL_RESET[CTRL_PROGRAM_ENABLE_BIT_BIT];
            err_q <= CTRL_RESET[CTRL_ERR_BIT];
            erase_q <= CTRL_RESET[CTRL_ERASE_BIT];
            op_q <= CTRL_RESET[3:0];
        end else if (ce) begin
            if (wr_fire && sel_ctrl) begin
                program_enable_bit_q <= ctrl_wd[CTRL_PROGRAM_ENABLE_BIT_BIT];
                erase_q <= ctrl_wd[CTRL_ERASE_BIT];
                op_q <= ctrl_wd[3:0];
            end
            if (start_ok) begin
                start_q <= 1'b1;
            end else if (state_q == FSPC_DONE) begin
                start_q <= 1'b0;
            end
            if (start_req && !start_ok) begin
                err_q <= 1'b1;
            end else if (state_q == FSPC_DONE) begin
                err_q <= 1'b0;
            end
        end
    end

    // Operation sequencer
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_q <= FSPC_IDLE;
            op_addr_q <= 24'h000000;
            idx_q <= 6'd0;
            tmr_q <= 12'd0;
            op_row_q <= 1'b0;
            op_word_q <= 1'b0;
            op_bulk_q <= 1'b0;
            cmd_q <= '0;
        end else if (ce) begin
            cmd_q.prog <= 1'b0;
            cmd_q.erase <= 1'b0;
            cmd_q.bulk <= 1'b0;
            case (state_q)
                FSPC_IDLE: begin
                    cmd_q.addr <= tbl_addr;
                    cmd_q.wdata <= 24'h000000;
                    if (start_ok) begin
                        op_row_q <= ~ctrl_wd[CTRL_ERASE_BIT] & (ctrl_wd[3:0] == OP_ROW_PROG);
                        op_word_q <= ~ctrl_wd[CTRL_ERASE_BIT] & (ctrl_wd[3:0] == OP_WORD_PROG);
                        op_bulk_q <= ctrl_wd[CTRL_ERASE_BIT] & (ctrl_wd[3:0] == OP_BULK_ERASE);
                        idx_q <= 6'd0;
                        if (ctrl_wd[CTRL_ERASE_BIT]) begin
                            op_addr_q <= tbl_addr & BLOCK_ALIGN_MASK;
                        end else if (ctrl_wd[3:0] == OP_ROW_PROG) begin
                            op_addr_q <= tbl_addr & ROW_ALIGN_MASK;
                        end else begin
                            op_addr_q <= tbl_addr;
                        end
                        // Undefined combinations complete with no array action
                        state_q <= op_valid ? FSPC_STREAM : FSPC_DONE;
                    end
                end
                FSPC_STREAM: begin
                    if (op_row_q) begin
                        cmd_q.addr <= op_addr_q | {17'h00000, idx_q, 1'b0};
                        cmd_q.wdata <= latch_mem[idx_q];
                        cmd_q.prog <= 1'b1;
                        idx_q <= idx_q + 6'd1;
                        if (idx_q == 6'(ROW_WORDS - 1)) begin
                            tmr_q <= 12'(PROG_CYC);
                            state_q <= FSPC_WAIT;
                        end
                    end else if (op_word_q) begin
                        cmd_q.addr <= op_addr_q;
                        cmd_q.wdata <= latch_mem[op_addr_q[6:1]];
                        cmd_q.prog <= 1'b1;
                        tmr_q <= 12'(PROG_CYC);
                        state_q <= FSPC_WAIT;
                    end else begin
                        cmd_q.addr <= op_addr_q;
                        cmd_q.erase <= 1'b1;
                        cmd_q.bulk <= op_bulk_q;
                        tmr_q <= 12'(ERASE_CYC);
                        state_q <= FSPC_WAIT;
                    end
                end
                FSPC_WAIT: begin
                    // Latches are not restored after programming
                    tmr_q <= tmr_q - 12'd1;
                    if (tmr_q == 12'd1) begin
                        state_q <= FSPC_DONE;
                    end
                end
                FSPC_DONE: begin
                    state_q <= FSPC_IDLE;
                end
                default: begin
                    state_q <= FSPC_IDLE;
                end
            endcase
        end
    end

    addr_form_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        ce && $past(ce) && state_q == FSPC_IDLE && $past(state_q) == FSPC_IDLE
        |-> cmd_q.addr == $past(tbl_addr))
        else $error("table address not formed from page and offset");

    two_cycle_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        ce && avs_write && !ack_q && !busy |-> avs_waitrequest ##1 (ce -> !avs_waitrequest))
        else $error("table write did not complete in two cycles");

    busy_stall_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        busy && req |-> avs_waitrequest && cpu_stall)
        else $error("bus answered during an operation");

    bad_start_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        start_req && key_q != 2'd2 |=> err_q && !start_q && state_q == FSPC_IDLE)
        else $error("start without unlock was not refused");

    program_enable_bit_gate_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        start_req && !ctrl_wd[CTRL_PROGRAM_ENABLE_BIT_BIT] |=> !busy && err_q)
        else $error("start ran with enable clear");

    start_clear_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        ce && state_q == FSPC_DONE |=> !start_q && !busy)
        else $error("start bit not cleared on completion");

    key_seq_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        wr_fire && sel_key && avs_byteenable[0] && avs_writedata[7:0] == KEY_SECOND && key_q == 2'd1
        |=> key_q == 2'd2)
        else $error("second key did not unlock");

    cfg_refuse_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        wr_fire && sel_dlow && page_q[CFG_PAGE_BIT] |=> latch_mem[$past(tbl_idx)] == $past(latch_mem[tbl_idx]))
        else $error("table write took effect in configuration space");

    erase_align_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        cmd_q.erase && !cmd_q.bulk |-> cmd_q.addr[9:0] == 10'h000)
        else $error("erase block not aligned");

    row_stream_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        ce && state_q == FSPC_STREAM && op_row_q && idx_q == 6'd0 |=> cmd_q.prog && cmd_q.addr[6:0] == 7'h00)
        else $error("row stream did not start at the row base");

    ctrl_rsvd_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        rd_fire && sel_ctrl |-> avs_readdata[12:7] == 6'h00 && avs_readdata[5:4] == 2'b00)
        else $error("reserved control bits read nonzero");

endmodule // fspc_ctrl

// *** verif/fspc_flash_model.sv ***
// Behavioural flash array model answering the controller's command port
module fspc_flash_model
    import fspc_pkg::*;
(
    input wire logic clk_sys,
    input wire fspc_pkg::fspc_cmd_s fl_cmd,
    output logic [23:0] fl_rdata,
    output int n_prog,
    output int n_erase,
    output int n_bulk
);
    timeunit 1ns;
    timeprecision 1ps;
    import fspc_pkg::*;
    logic [23:0] mem [int];
    int wbase;
    initial begin
        n_prog = 0;
        n_erase = 0;
        n_bulk = 0;
    end
    // Array changes only on command pulses
    always @(posedge clk_sys) begin
        if (fl_cmd.prog === 1'b1) begin
            mem[int'(fl_cmd.addr[23:1])] = fl_cmd.wdata;
            n_prog++;
        end
        if (fl_cmd.erase === 1'b1) begin
            n_erase++;
            if (fl_cmd.bulk === 1'b1) begin
                n_bulk++;
                mem.delete();
            end else begin
                wbase = int'(fl_cmd.addr[23:10]) * 512;
                for (int i = 0; i < 512; i++) begin
                    mem.delete(wbase + i);
                end
            end
        end
    end
    // Erased cells read as all ones
    always @(fl_cmd.addr or n_prog or n_erase) begin
        fl_rdata = mem.exists(int'(fl_cmd.addr[23:1])) ? mem[int'(fl_cmd.addr[23:1])] : 24'hFFFFFF;
    end
endmodule // fspc_flash_model

// *** verif/fspc_ctrl_tb.sv ***
// Self-checking bench for the flash self-programming controller
module fspc_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import fspc_pkg::*;
    logic clk_sys = 1'b0;
    logic ce = 1'b1;
    logic rstn = 1'b0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic cpu_stall;
    logic [23:0] fl_rdata;
    fspc_cmd_s fl_cmd;
    int error_cnt = 0;
    int n_tests = 0;
    int stall_cnt = 0;
    int n_prog, n_erase, n_bulk, s0;
    logic [23:0] exp_row [64];
    logic [15:0] ops [4] = '{16'hC00F, 16'hC002, 16'hC043, 16'hC041};

    fspc_ctrl i_dut (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .avs_address(avs_address),
        .avs_byteenable(avs_byteenable), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .fl_cmd(fl_cmd), .fl_rdata(fl_rdata), .cpu_stall(cpu_stall));
    fspc_flash_model i_flash (.clk_sys(clk_sys), .fl_cmd(fl_cmd), .fl_rdata(fl_rdata),
        .n_prog(n_prog), .n_erase(n_erase), .n_bulk(n_bulk));

    always #25 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (cpu_stall === 1'b1) stall_cnt++;

    task automatic complete_run;
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be,
        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_sys);
        avs_write <= w;
        avs_read <= ~w;
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 5000);
        if (n >= 5000) chk(32'h1, 32'h0, "bus answer timeout");
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be = 4'h3);
        logic [31:0] q;
        bus(1'b1, a, d, be, q);
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] exp, input string msg);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, 4'h3, q);
        chk(q, exp, msg);
    endtask

    task automatic tread(input logic [15:0] ea, input logic [23:0] exp);
        wr(OFF_EADDR, {16'h0, ea});
        rd(OFF_DLOW, {16'h0, exp[15:0]}, "table read low");
        rd(OFF_DHIGH, {24'h0, exp[23:16]}, "table read high");
    endtask

    task automatic start_op(input logic [15:0] c, input logic [15:0] exp);
        wr(OFF_KEY, 32'h55);
        wr(OFF_KEY, 32'hAA);
        wr(OFF_CTRL, {16'h0, c});
        rd(OFF_CTRL, {16'h0, exp}, "control after operation");
    endtask

    initial begin
        #3000000;
        error_cnt++;
        complete_run();
    end

    initial begin
        repeat (12) @(posedge clk_sys);
        rstn <= 1'b1;
        rd(OFF_CTRL, 32'h0, "control reset");
        rd(OFF_KEY, 32'h0, "key reads zero");
        wr(OFF_CTRL, 32'h7FFF);
        rd(OFF_CTRL, 32'h404F, "control mask");
        wr(OFF_CTRL, 32'h8001);
        rd(OFF_CTRL, 32'h2001, "start without enable");
        wr(OFF_CTRL, 32'hC001);
        rd(OFF_CTRL, 32'h6001, "start without unlock");
        wr(OFF_PAGE, 32'h0);
        wr(OFF_EADDR, 32'h8E);
        wr(OFF_DLOW, 32'hDEAD);
        for (int i = 63; i >= 0; i--) begin
            exp_row[i] = {8'(i), 8'(8'hC3 ^ i), 8'(i * 5)};
            wr(OFF_EADDR, 32'h80 + 2 * i);
            wr(OFF_DLOW, {16'h0, exp_row[i][15:0]});
            wr(OFF_DHIGH, {24'h0, exp_row[i][23:16]});
        end
        wr(OFF_EADDR, 32'h92);
        wr(OFF_DLOW, 32'h5A, 4'h1);
        exp_row[9][7:0] = 8'h5A;
        tread(16'h0080, 24'hFFFFFF);
        chk(n_prog, 0, "no array write from latches");
        s0 = stall_cnt;
        start_op(16'hC001, 16'h4001);
        chk(n_prog, 64, "row program pulses");
        chk(32'(stall_cnt - s0 >= PROG_CYC), 1, "stall during program");
        for (int i = 0; i < 64; i++) begin
            tread(16'h80 + 16'(2 * i), exp_row[i]);
        end
        wr(OFF_PAGE, 32'h1);
        wr(OFF_EADDR, 32'h0102);
        wr(OFF_DLOW, 32'h3456);
        wr(OFF_DHIGH, 32'h12);
        wr(OFF_PAGE, 32'h80);
        wr(OFF_DLOW, 32'hBEEF);
        wr(OFF_PAGE, 32'h1);
        ce <= 1'b0;
        fork
            rd(OFF_PAGE, 32'h1, "read with clock enable low");
            begin
                repeat (6) @(posedge clk_sys);
                chk(32'(avs_waitrequest), 32'h1, "wait while frozen");
                ce <= 1'b1;
            end
        join
        start_op(16'hC003, 16'h4003);
        chk(n_prog, 65, "word program pulse");
        tread(16'h0102, 24'h123456);
        wr(OFF_PAGE, 32'h0);
        tread(16'h0102, 24'hFFFFFF);
        wr(OFF_KEY, 32'h55);
        wr(OFF_CTRL, 32'h4003);
        wr(OFF_KEY, 32'hAA);
        wr(OFF_CTRL, 32'hC003);
        rd(OFF_CTRL, 32'h6003, "broken unlock");
        chk(n_prog, 65, "no pulse after broken unlock");
        wr(OFF_EADDR, 32'h0080);
        start_op(16'hC042, 16'h4042);
        chk(n_erase, 1, "block erase pulse");
        tread(16'h00FE, 24'hFFFFFF);
        wr(OFF_PAGE, 32'h1);
        tread(16'h0102, 24'h123456);
        for (int i = 0; i < 4; i++) begin
            start_op(ops[i], ops[i] & 16'h7FFF);
        end
        chk(n_prog + n_erase, 66, "no pulse for no-op codes");
        start_op(16'hC04F, 16'h404F);
        chk(n_bulk, 1, "bulk erase pulse");
        tread(16'h0102, 24'hFFFFFF);
        complete_run();
    end
endmodule // fspc_ctrl_tb
